// [src/sfsc_consts.vh]
// Purpose: constants for the shared flash and sleep control block
// Assumes: 8-bit host index port, 100 MHz clock
// Notes:   definitions only
`ifndef SFSC_CONSTS_VH
`define SFSC_CONSTS_VH
// ****************************************
// register indexes and reset values
// ****************************************
`define SFSC_IDX_CLK_STOP      8'h94
`define SFSC_IDX_FLASH_PAGE    8'h95
`define SFSC_PAGE_RESET        2'h3
`define SFSC_STOP_RESET        1'h0
`define SFSC_BIT_IDLE          7
`define SFSC_BIT_HOST_FLASH    6
// ****************************************
// core power control
// ****************************************
`define SFSC_PCON_ADDR         8'h87
`define SFSC_PCON_IDLE_BIT     0
`define SFSC_SRC_RING_EN_BIT   4
`define SFSC_SRC_FAST_BIT      5
// ring oscillator settle time, in ns, and its cycle count
`define SFSC_RING_SETTLE_NS    200
`define SFSC_CLK_PERIOD_NS     10
`define SFSC_RING_SETTLE_CYC   ((`SFSC_RING_SETTLE_NS + `SFSC_CLK_PERIOD_NS - 1) / `SFSC_CLK_PERIOD_NS)
`define SFSC_CNT_W             8
// ****************************************
// wake source bit positions
// ****************************************
`define SFSC_WAKE_N            19
`define SFSC_WK_RING1          0
`define SFSC_WK_RING2          1
`define SFSC_WK_GENERAL        2
`define SFSC_WK_FALL_LO        3
`define SFSC_WK_FALL_HI        8
`define SFSC_WK_SERIAL         9
`define SFSC_WK_EE_LO          10
`define SFSC_WK_EE_HI          13
`define SFSC_WK_ALARM          14
`define SFSC_WK_HIBERNATION_TIMER_WAKE         15
`define SFSC_ANY_KEY_WAKE         16
`define SFSC_WK_IR_A           17
`define SFSC_WK_IR_B           18
// sync preset; rest-high pins see no edge, rise-only sources see a harmless fall
`define SFSC_WAKE_IDLE         19'h7ffff
`endif

// [src/sfsc_shared_flash_and_sleep_control.v]
// Purpose: shared flash arbitration between host and core, core idle/sleep clock control
// Assumes: single 100 MHz clock, synchronous active-high reset standing for main-plane POR
// Notes:   core clock gating is exposed as enables; wake sources are external pins
//
// How it works
// - host page picks one of four windows
// - host clock stop takes effect only with request and core reset low
// - host access needs chip select plus strobe
// - flash address from system address and page
// - core reset fall sets stop, page 03h
// - flash strobes follow current owner's strobes
// - only stop bit writable, rest read-only
// - status D7 shows core idle
// - status D6 shows host flash ownership
// - idle bit gates cpu clock only
// - idle preserves registers and pin levels
// - enabled interrupt clears idle bit
// - power-on reset ends idle and restarts
// - firmware sleep entry order
// - sleep stops all clocks, keeps RAM
// - wake starts ring, resumes when stable
// - firmware may return to fast clock
// - sleep exit keeps registers and pins
// - wake inputs work without second supply
// - pin and internal events wake core
// - sleep entered on user command
// - wake status clears on read
// - infrared wakes maskable, falling edge
`timescale 1ns/1ps
`include "sfsc_consts.vh"
`default_nettype none
module sfsc_shared_flash_and_sleep_control (
    // clock and reset
    input  wire         clock,
    input  wire         reset,
    // host index port
    input  wire [7:0]   hostIndex,
    input  wire [7:0]   hostWriteData,
    input  wire         hostWriteStrobe,
    output reg  [7:0]   hostReadData_ff,
    // host flash cycle pins
    input  wire [15:0]  systemAddress,
    input  wire         flash_chip_select_n,
    input  wire         memReadStrobe_n,
    input  wire         memWriteStrobe_n,
    // core side flash request
    input  wire [17:0]  coreFlashAddress,
    input  wire         coreFlashRead_n,
    input  wire         coreFlashWrite_n,
    input  wire         coreResetOut,
    // core power control
    input  wire [7:0]   coreSfrAddress,
    input  wire [7:0]   coreSfrWriteData,
    input  wire         coreSfrWrite,
    input  wire         enabledIrq,
    input  wire [7:0]   core_clock_source_control,
    input  wire         sleep_indicator,
    input  wire         statusRead,
    // wake inputs
    input  wire         ring_indicator_1_n,
    input  wire         ring_indicator_2_n,
    input  wire         general_wake_pin_n,
    input  wire [5:0]   falling_wake_pin_1,
    input  wire         serial_bus_data_wake,
    input  wire [3:0]   either_edge_wake_1,
    input  wire         clock_alarm_wake,
    input  wire         hibernation_timer_wake,
    input  wire [7:0]   key_scan_input,
    input  wire         infrared_wake_a,
    input  wire         infrared_receive,
    input  wire [18:0]  wakeMask,
    // flash pins
    output reg  [17:0]  flashAddress_ff,
    output wire         flash_read_strobe_n,
    output wire         flash_write_strobe_n,
    // core clock and state
    output wire         cpuClockEnable,
    output wire         periphClockEnable,
    output wire         ringOscEnable,
    output reg          idle_request_bit_ff,
    output reg          sleeping_ff,
    output reg  [18:0]  wakeStatus_ff
);
    // ****************************************
    // host registers
    // ****************************************
    reg  [1:0]  host_flash_page_ff;
    reg         core_clock_stop_request_ff;
    reg         resetOutDly_ff;
    reg         ringWait_ff;
    reg  [`SFSC_CNT_W-1:0] ringCnt_ff;
    wire        hostOwns;
    wire        resetFall;
    wire        wakeHit;

    assign resetFall = resetOutDly_ff & ~coreResetOut;
    assign hostOwns  = core_clock_stop_request_ff & ~coreResetOut;

    // reset-out edge tracker; core logic shares this clock, no sync
    always @(posedge clock) begin
        if (reset) begin
            resetOutDly_ff <= 1'b0;
        end else begin
            resetOutDly_ff <= coreResetOut;
        end
    end

    // page and stop writes; the core reset release wins so the host boots top page
    always @(posedge clock) begin
        if (reset) begin
            host_flash_page_ff         <= `SFSC_PAGE_RESET;
            core_clock_stop_request_ff <= `SFSC_STOP_RESET;
        end else if (resetFall) begin
            host_flash_page_ff         <= `SFSC_PAGE_RESET;
            core_clock_stop_request_ff <= 1'b1;
        end else if (hostWriteStrobe) begin
            if (hostIndex == `SFSC_IDX_FLASH_PAGE) begin
                host_flash_page_ff <= hostWriteData[1:0];
            end
            if (hostIndex == `SFSC_IDX_CLK_STOP) begin
                core_clock_stop_request_ff <= hostWriteData[0];
            end
        end
    end

    // host read mux; unmapped indexes read zero
    always @(posedge clock) begin
        if (reset) begin
            hostReadData_ff <= 8'h00;
        end else begin
            case (hostIndex)
                `SFSC_IDX_FLASH_PAGE: begin
                    hostReadData_ff <= {6'h00, host_flash_page_ff};
                end
                `SFSC_IDX_CLK_STOP: begin
                    hostReadData_ff <= {idle_request_bit_ff, hostOwns, 5'h00,
                                        core_clock_stop_request_ff};
                end
                default: begin
                    hostReadData_ff <= 8'h00;
                end
            endcase
        end
    end

    // ****************************************
    // flash multiplexer
    // ****************************************
    // strobes are combinational so the flash sees the owner's timing directly
    assign flash_read_strobe_n  = hostOwns ? (flash_chip_select_n | memReadStrobe_n)
                                           : coreFlashRead_n;
    assign flash_write_strobe_n = hostOwns ? (flash_chip_select_n | memWriteStrobe_n)
                                           : coreFlashWrite_n;

    // address is registered; it settles one cycle after the strobe changes
    always @(posedge clock) begin
        if (reset) begin
            flashAddress_ff <= 18'h00000;
        end else if (hostOwns) begin
            flashAddress_ff <= {host_flash_page_ff, systemAddress};
        end else begin
            flashAddress_ff <= coreFlashAddress;
        end
    end

    // ****************************************
    // wake detection
    // ****************************************
    wire [18:0] wakeRaw;
    reg  [18:0] wakeSync1_ff;
    reg  [18:0] wakeSync2_ff;
    reg  [18:0] wakePrev_ff;
    wire [18:0] wakeEdge;
    wire        anyKey;

    assign anyKey  = ~(&key_scan_input);
    assign wakeRaw = {infrared_receive, infrared_wake_a, anyKey, hibernation_timer_wake,
                      clock_alarm_wake, either_edge_wake_1, serial_bus_data_wake,
                      falling_wake_pin_1, general_wake_pin_n, ring_indicator_2_n,
                      ring_indicator_1_n};

    // two-stage sync; pins run off the main plane so they stay live in sleep
    always @(posedge clock) begin
        if (reset) begin
            wakeSync1_ff <= `SFSC_WAKE_IDLE;
            wakeSync2_ff <= `SFSC_WAKE_IDLE;
            wakePrev_ff  <= `SFSC_WAKE_IDLE;
        end else begin
            wakeSync1_ff <= wakeRaw;
            wakeSync2_ff <= wakeSync1_ff;
            wakePrev_ff  <= wakeSync2_ff;
        end
    end

    // per-source edge polarity
    genvar gi;
    generate
        for (gi = 0; gi < `SFSC_WAKE_N; gi = gi + 1) begin : gWake
            if (gi >= `SFSC_WK_EE_LO && gi <= `SFSC_WK_EE_HI) begin : gBoth
                assign wakeEdge[gi] = wakeSync2_ff[gi] ^ wakePrev_ff[gi];
            end else if (gi == `SFSC_WK_ALARM || gi == `SFSC_WK_HIBERNATION_TIMER_WAKE || gi == `SFSC_ANY_KEY_WAKE) begin : gRise
                assign wakeEdge[gi] = wakeSync2_ff[gi] & ~wakePrev_ff[gi];
            end else begin : gFall
                assign wakeEdge[gi] = ~wakeSync2_ff[gi] & wakePrev_ff[gi];
            end
        end
    endgenerate

    // sticky status; a new event in the read cycle survives the clear
    always @(posedge clock) begin
        if (reset) begin
            wakeStatus_ff <= 19'h00000;
        end else if (statusRead) begin
            wakeStatus_ff <= wakeEdge & ~wakeMask;
        end else begin
            wakeStatus_ff <= wakeStatus_ff | (wakeEdge & ~wakeMask);
        end
    end

    assign wakeHit = |(wakeEdge & ~wakeMask);

    // ****************************************
    // idle and sleep control
    // ****************************************
    localparam [2:0] ST_RUN   = 3'b001;
    localparam [2:0] ST_SLEEP = 3'b010;
    localparam [2:0] ST_WAKE  = 3'b100;
    reg  [2:0] state_ff;
    reg  [2:0] nxt_state;
    wire       idleWrite;
    wire       ringDone;
    // settle count cut to counter width on purpose; the macro is a plain integer
    localparam [31:0] RING_SETTLE = `SFSC_RING_SETTLE_CYC;

    assign idleWrite = coreSfrWrite & (coreSfrAddress == `SFSC_PCON_ADDR)
                       & coreSfrWriteData[`SFSC_PCON_IDLE_BIT];

    // ring counter at zero: settle finished, or no wake-up under way
    assign ringDone = (ringCnt_ff == {`SFSC_CNT_W{1'b0}});

    // idle bit: reset ends idle and restarts; interrupt clear wins over a set
    always @(posedge clock) begin
        if (reset) begin
            idle_request_bit_ff <= 1'b0;
        end else if (enabledIrq || (state_ff == ST_WAKE && ringDone)) begin
            idle_request_bit_ff <= 1'b0;
        end else if (idleWrite) begin
            idle_request_bit_ff <= 1'b1;
        end
    end

    // firmware sequence makes sleep: ring on, sleep flag set, then idle bit
    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            ST_RUN: begin
                if (idleWrite && sleep_indicator) begin
                    nxt_state = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (wakeHit) begin
                    nxt_state = ST_WAKE;
                end
            end
            ST_WAKE: begin
                if (ringDone) begin
                    nxt_state = ST_RUN;
                end
            end
            default: begin
                nxt_state = ST_RUN;
            end
        endcase
    end

    // state and ring settle counter
    always @(posedge clock) begin
        if (reset) begin
            state_ff    <= ST_RUN;
            ringCnt_ff  <= {`SFSC_CNT_W{1'b0}};
            sleeping_ff <= 1'b0;
            ringWait_ff <= 1'b0;
        end else begin
            state_ff    <= nxt_state;
            sleeping_ff <= (nxt_state != ST_RUN);
            ringWait_ff <= (nxt_state == ST_WAKE);
            if (state_ff == ST_SLEEP && wakeHit) begin
                ringCnt_ff <= RING_SETTLE[`SFSC_CNT_W-1:0];
            end else if (!ringDone) begin
                ringCnt_ff <= ringCnt_ff - 1'b1;
            end
        end
    end

    // clock gates; registers are never reset by idle or sleep
    assign cpuClockEnable    = ~idle_request_bit_ff & ~hostOwns & ~sleeping_ff;
    assign periphClockEnable = ~sleeping_ff;
    assign ringOscEnable     = ringWait_ff |
                               (~sleeping_ff & core_clock_source_control[`SFSC_SRC_RING_EN_BIT]);
endmodule
`default_nettype wire

// [tb/sfsc_asserts.sv]
// Purpose: port checks for shared flash and sleep control
// Assumes: one clock, sync active-high reset
// Notes:   bound onto the top module
`timescale 1ns/1ps
`default_nettype none
module sfsc_asserts (
    // clock and reset
    input wire logic        clock,
    input wire logic        reset,
    // host side
    input wire logic [7:0]  hostIndex,
    input wire logic        hostWriteStrobe,
    input wire logic [7:0]  hostReadData_ff,
    input wire logic [15:0] systemAddress,
    input wire logic        flash_chip_select_n,
    input wire logic        memReadStrobe_n,
    // core side
    input wire logic        coreFlashRead_n,
    input wire logic        coreResetOut,
    input wire logic [7:0]  coreSfrAddress,
    input wire logic [7:0]  coreSfrWriteData,
    input wire logic        coreSfrWrite,
    input wire logic        enabledIrq,
    // outputs
    input wire logic [17:0] flashAddress_ff,
    input wire logic        flash_read_strobe_n,
    input wire logic        cpuClockEnable,
    input wire logic        ringOscEnable,
    input wire logic        idle_request_bit_ff,
    input wire logic        sleeping_ff
);
    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    // ring starting while asleep opens the wake-up
    sequence wakeStart_s;
        $rose(ringOscEnable) && sleeping_ff;
    endsequence
    // host read reaching the flash, core quiet
    sequence hostRead_s;
        !flash_chip_select_n && !memReadStrobe_n && coreFlashRead_n && !flash_read_strobe_n;
    endsequence
    page_upper_a: assert property (hostIndex == 8'h95 |=> hostReadData_ff[7:2] == 6'h00)
        else $error("page upper bits not zero");
    stop_reserved_a: assert property (hostIndex == 8'h94 |=> hostReadData_ff[5:1] == 5'h00)
        else $error("stop register reserved bits set");
    read_cause_a: assert property (!flash_read_strobe_n |-> !coreFlashRead_n || !(flash_chip_select_n || memReadStrobe_n))
        else $error("flash read without a requester");
    host_addr_a: assert property (hostRead_s |=> flashAddress_ff[15:0] == $past(systemAddress))
        else $error("flash address not from system address");
    idle_entry_a: assert property (coreSfrWrite && coreSfrAddress == 8'h87 && coreSfrWriteData[0] && !enabledIrq |=> idle_request_bit_ff)
        else $error("idle bit not set");
    irq_exit_a: assert property (enabledIrq && !sleeping_ff |=> !idle_request_bit_ff)
        else $error("idle bit kept after interrupt");
    wake_settle_a: assert property (wakeStart_s |-> (!cpuClockEnable) [*8] ##[8:24] !idle_request_bit_ff)
        else $error("wake-up did not settle and resume");
    boot_page_a: assert property ($fell(coreResetOut) ##0 (hostIndex == 8'h95 && !hostWriteStrobe) [*3] |=> hostReadData_ff[1:0] == 2'h3)
        else $error("boot page not loaded");
endmodule
bind sfsc_shared_flash_and_sleep_control sfsc_asserts i_asserts (.*);
`default_nettype wire

// [tb/sfsc_flash_model.sv]
// Purpose: external flash seen from the shared flash pins
// Assumes: strobes active low, address settles one cycle after a strobe falls
// Notes:   counts finished accesses, no data bus modelled
`timescale 1ns/1ps
`default_nettype none
module sfsc_flash_model (
    // flash pins
    input  wire logic        clock,
    input  wire logic [17:0] flashAddress_ff,
    input  wire logic        flash_read_strobe_n,
    input  wire logic        flash_write_strobe_n,
    // finished accesses
    output var  logic [7:0]  readCount_ff,
    output var  logic [7:0]  writeCount_ff,
    output var  logic [17:0] lastAddress_ff
);
    // ****************************************
    // access tracking
    // ****************************************
    logic rdSeen_ff = 1'b0;
    logic wrSeen_ff = 1'b0;
    initial begin
        readCount_ff = 8'h00;
        writeCount_ff = 8'h00;
        lastAddress_ff = 18'h00000;
    end
    // the part acts only while a strobe is low; a rising strobe ends it
    always @(posedge clock) begin
        rdSeen_ff <= !flash_read_strobe_n;
        wrSeen_ff <= !flash_write_strobe_n;
        if (rdSeen_ff && flash_read_strobe_n)
            readCount_ff <= readCount_ff + 8'h01;
        if (wrSeen_ff && flash_write_strobe_n)
            writeCount_ff <= writeCount_ff + 8'h01;
        if (wrSeen_ff && flash_write_strobe_n)
            lastAddress_ff <= flashAddress_ff;
    end
endmodule
`default_nettype wire

// [tb/testbench.sv]
// Purpose: self-checking bench for shared flash and sleep control
// Assumes: 100 MHz clock, inputs change at the falling edge
// Notes:   wake pins rest at their idle level so the presets raise no wake event
`timescale 1ns/1ps
`default_nettype none
module testbench;
    // ****************************************
    // stimulus, design and flash
    // ****************************************
    typedef struct packed { logic [7:0] idx, dat, exp; } sfsc_row_t;
    logic clock = 1'b0, reset = 1'b1, hostWriteStrobe = 1'b0, coreSfrWrite = 1'b0, enabledIrq = 1'b0;
    logic sleep_indicator = 1'b0, statusRead = 1'b0, coreResetOut = 1'b1, ring_indicator_1_n = 1'b1;
    logic flash_chip_select_n = 1'b1, memReadStrobe_n = 1'b1, memWriteStrobe_n = 1'b1;
    logic coreFlashRead_n = 1'b1, coreFlashWrite_n = 1'b1, clock_alarm_wake = 1'b0, infrared_receive = 1'b1;
    logic [7:0] hostIndex = 8'h00, hostWriteData = 8'h00, coreSfrAddress = 8'h00, coreSfrWriteData = 8'h00;
    logic [7:0] core_clock_source_control = 8'h00, key_scan_input = 8'hff, readCount_ff, writeCount_ff;
    logic ring_indicator_2_n = 1'b1, general_wake_pin_n = 1'b1, serial_bus_data_wake = 1'b1;
    logic hibernation_timer_wake = 1'b0, infrared_wake_a = 1'b1;
    logic [15:0] systemAddress = 16'h0000;
    logic [17:0] coreFlashAddress = 18'h00000, flashAddress_ff, lastAddress_ff;
    logic [5:0] falling_wake_pin_1 = 6'h3f;
    logic [3:0] either_edge_wake_1 = 4'hf;
    logic [18:0] wakeMask = 19'h00001, wakeStatus_ff;
    logic [7:0] hostReadData_ff;
    logic flash_read_strobe_n, flash_write_strobe_n, cpuClockEnable, periphClockEnable, ringOscEnable;
    logic idle_request_bit_ff, sleeping_ff;
    int n_mismatch = 0, samples_checked = 0, cycles = 0, k;
    sfsc_row_t rows [6] = '{'{8'h95, 8'h01, 8'h01}, '{8'h95, 8'hff, 8'h03}, '{8'h95, 8'h02, 8'h02},
                            '{8'h94, 8'hff, 8'h01}, '{8'h94, 8'h00, 8'h00}, '{8'h33, 8'hff, 8'h00}};
    sfsc_shared_flash_and_sleep_control i_dut (.*);
    sfsc_flash_model i_flash (.*);
    always #5 clock = ~clock;
    // hang guard, well above the expected run of under two hundred cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            results();
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(negedge clock);
    endtask
    // index write, then read data of the same index is settled
    task hw(input logic [7:0] i, input logic [7:0] d);
        @(negedge clock);
        hostIndex = i;
        hostWriteData = d;
        hostWriteStrobe = 1'b1;
        cyc(1);
        hostWriteStrobe = 1'b0;
        cyc(1);
    endtask
    task sfr;
        @(negedge clock);
        coreSfrAddress = 8'h87;
        coreSfrWriteData = 8'h01;
        coreSfrWrite = 1'b1;
        cyc(1);
        coreSfrWrite = 1'b0;
    endtask
    // wake status after sync delay, then clear it
    task wk(input logic [18:0] e);
        cyc(5);
        chk(wakeStatus_ff, e);
        statusRead = 1'b1;
        cyc(1);
        statusRead = 1'b0;
    endtask
    task results;
        $display("checks=%0d mismatches=%0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (4) @(posedge clock);
        @(negedge clock);
        reset = 1'b0;
        foreach (rows[r]) begin
            hw(rows[r].idx, rows[r].dat);
            chk(hostReadData_ff, rows[r].exp);
        end
        $display("register table done");
        hw(8'h95, 8'h01);
        coreResetOut = 1'b0;
        cyc(3);
        chk(hostReadData_ff, 8'h03);
        chk(cpuClockEnable, 1'b0);
        hw(8'h94, 8'h01);
        chk(hostReadData_ff, 8'h41);
        hw(8'h95, 8'h02);
        systemAddress = 16'h1234;
        flash_chip_select_n = 1'b0;
        memReadStrobe_n = 1'b0;
        cyc(2);
        chk(flash_write_strobe_n, 1'b1);
        chk(flashAddress_ff, 18'h21234);
        memReadStrobe_n = 1'b1;
        memWriteStrobe_n = 1'b0;
        cyc(2);
        chk(flash_write_strobe_n, 1'b0);
        flash_chip_select_n = 1'b1;
        cyc(1);
        chk(flash_write_strobe_n, 1'b1);
        memWriteStrobe_n = 1'b1;
        cyc(2);
        chk({readCount_ff, writeCount_ff, lastAddress_ff[15:0]}, 32'h01011234);
        $display("host flash done");
        hw(8'h94, 8'h00);
        coreFlashAddress = 18'h3abcd;
        coreFlashRead_n = 1'b0;
        cyc(2);
        chk(flashAddress_ff, 18'h3abcd);
        coreFlashRead_n = 1'b1;
        flash_chip_select_n = 1'b0;
        memReadStrobe_n = 1'b0;
        cyc(1);
        chk(flash_read_strobe_n, 1'b1);
        flash_chip_select_n = 1'b1;
        memReadStrobe_n = 1'b1;
        sfr();
        cyc(1);
        chk({hostReadData_ff, cpuClockEnable, periphClockEnable}, 10'h201);
        core_clock_source_control = 8'h10;
        enabledIrq = 1'b1;
        cyc(1);
        enabledIrq = 1'b0;
        chk(idle_request_bit_ff, 1'b0);
        chk(ringOscEnable, 1'b1);
        $display("idle done");
        sleep_indicator = 1'b1;
        sfr();
        sleep_indicator = 1'b0;
        cyc(2);
        chk({sleeping_ff, cpuClockEnable, periphClockEnable, ringOscEnable}, 4'h8);
        ring_indicator_1_n = 1'b0;
        cyc(6);
        chk({sleeping_ff, wakeStatus_ff[0]}, 2'h2);
        key_scan_input = 8'hf7;
        cyc(8);
        chk({sleeping_ff, ringOscEnable, cpuClockEnable}, 3'h6);
        for (k = 0; k < 60 && sleeping_ff !== 1'b0; k++)
            cyc(1);
        chk({sleeping_ff, idle_request_bit_ff, wakeStatus_ff[16]}, 3'h1);
        hostIndex = 8'h95;
        core_clock_source_control = 8'h00;
        cyc(2);
        chk({hostReadData_ff, ringOscEnable}, 9'h004);
        key_scan_input = 8'hff;
        ring_indicator_1_n = 1'b1;
        wakeMask = 19'h00000;
        wk(19'h10000);
        chk(wakeStatus_ff, 19'h00000);
        either_edge_wake_1 = 4'he;
        wk(19'h00400);
        either_edge_wake_1 = 4'hf;
        wk(19'h00400);
        clock_alarm_wake = 1'b1;
        wk(19'h04000);
        infrared_receive = 1'b0;
        wk(19'h40000);
        falling_wake_pin_1 = 6'h3e;
        wk(19'h00008);
        falling_wake_pin_1 = 6'h3f;
        wk(19'h00000);
        ring_indicator_2_n = 1'b0;
        general_wake_pin_n = 1'b0;
        serial_bus_data_wake = 1'b0;
        wk(19'h00206);
        ring_indicator_2_n = 1'b1;
        general_wake_pin_n = 1'b1;
        serial_bus_data_wake = 1'b1;
        hibernation_timer_wake = 1'b1;
        infrared_wake_a = 1'b0;
        wk(19'h28000);
        $display("wake done");
        sfr();
        reset = 1'b1;
        cyc(2);
        reset = 1'b0;
        hostIndex = 8'h95;
        cyc(2);
        chk({idle_request_bit_ff, hostReadData_ff, wakeStatus_ff}, 28'h0180000);
        $display("reset done");
        results();
    end
endmodule
`default_nettype wire
